// File: verilog/synth_cal_defs.svh
`ifndef SYNTH_CAL_DEFS_SVH
`define SYNTH_CAL_DEFS_SVH

// register port addresses
`define ADDR_CAL_CONTROL 6'h28
`define ADDR_OSC_CURRENT 6'h29
`define ADDR_PUMP_CONTROL 6'h2a
`define ADDR_BANDPASS 6'h2b
`define REG_COUNT 4

// reset values
`define RST_CAL_CONTROL 16'h5002
`define RST_OSC_CURRENT 16'h0600
`define RST_PUMP_CONTROL 16'h82dd
`define RST_BANDPASS 16'h0000

// writable bits, reserved and read-only bits excluded
`define WMASK_CAL_CONTROL 16'hffff
`define WMASK_OSC_CURRENT 16'h7fc0
`define WMASK_PUMP_CONTROL 16'hffff
`define WMASK_BANDPASS 16'h7f80

// calibration control fields
`define CTL_TX_SKIP 15
`define CTL_LONG_MEAS 14
`define CTL_REF_HI 13
`define CTL_REF_LO 10
`define CTL_K_HI 9
`define CTL_K_LO 4
`define CTL_DAC_EN 3
`define CTL_DAC_HI 2
`define CTL_DAC_LO 0

// oscillator current fields
`define OSC_SPEED_HI 14
`define OSC_SPEED_LO 13
`define OSC_OVR_EN 12
`define OSC_OVR_HI 11
`define OSC_OVR_LO 6
`define OSC_RES_HI 5
`define OSC_RES_LO 0

// charge pump fields
`define PMP_CAL_OFF 15
`define PMP_OVR_EN 14
`define PMP_UP 13
`define PMP_DOWN 12
`define PMP_DISABLE 11
`define PMP_PHASE_DET_RESET_DELAY 10
`define PMP_STEP_HI 9
`define PMP_STEP_LO 8
`define PMP_END_HI 7
`define PMP_END_LO 4
`define PMP_BEGIN_HI 3
`define PMP_BEGIN_LO 0

// bandpass fields
`define BPF_OVR_EN 14
`define BPF_OVR_HI 13
`define BPF_OVR_LO 7
`define BPF_RES_HI 6
`define BPF_RES_LO 0

// timing
`define CLOCK_PERIOD_NS 20
`define CAL_TIME_SHORT_NS 37000
`define CAL_TIME_LONG_NS 57000
`define CAL_CYCLES_SHORT (`CAL_TIME_SHORT_NS / `CLOCK_PERIOD_NS)
`define CAL_CYCLES_LONG (`CAL_TIME_LONG_NS / `CLOCK_PERIOD_NS)
`define STEP_TIME_0_NS 250
`define STEP_TIME_1_NS 500
`define STEP_TIME_2_NS 1000
`define STEP_TIME_3_NS 4000
`define STEP_CYCLES_0 (`STEP_TIME_0_NS / `CLOCK_PERIOD_NS)
`define STEP_CYCLES_1 (`STEP_TIME_1_NS / `CLOCK_PERIOD_NS)
`define STEP_CYCLES_2 (`STEP_TIME_2_NS / `CLOCK_PERIOD_NS)
`define STEP_CYCLES_3 (`STEP_TIME_3_NS / `CLOCK_PERIOD_NS)

`endif

// File: verilog/synth_cal_pkg.sv
package synth_cal_pkg;
  typedef enum logic {CAL_IDLE = 1'b0, CAL_RUN = 1'b1} cal_state_type;
  typedef enum logic {STEP_HOLD = 1'b0, STEP_RUN = 1'b1} step_state_type;
endpackage

// File: verilog/pump_current_stepper.sv
`include "synth_cal_defs.svh"

module pump_current_stepper
  import synth_cal_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic startStep,
  input wire logic overrideEn,
  input wire logic [3:0] beginValue,
  input wire logic [3:0] endValue,
  input wire logic [1:0] interval,
  output logic [3:0] pumpCurrent
);
  step_state_type state_ff, nxt_state;
  logic [3:0] level_ff, nxt_level;
  logic [7:0] count_ff, nxt_count;

  function automatic logic [7:0] stepLast(input logic [1:0] code);
    unique case (code)
      2'h0: stepLast = 8'(`STEP_CYCLES_0 - 1);
      2'h1: stepLast = 8'(`STEP_CYCLES_1 - 1);
      2'h2: stepLast = 8'(`STEP_CYCLES_2 - 1);
      2'h3: stepLast = 8'(`STEP_CYCLES_3 - 1);
    endcase
  endfunction

  always_comb
  begin
    nxt_state = state_ff;
    nxt_level = level_ff;
    nxt_count = count_ff;
    if (startStep)
    begin
      nxt_level = beginValue; // R15
      nxt_count = 8'h00;
      nxt_state = (beginValue > endValue) ? STEP_RUN : STEP_HOLD;
    end
    else
    begin
      unique case (state_ff)
        STEP_HOLD: nxt_count = 8'h00; // R20
        STEP_RUN:
        begin
          if (count_ff >= stepLast(interval))
          begin
            nxt_count = 8'h00;
            nxt_level = level_ff - 4'h1; // R15
            if (level_ff - 4'h1 <= endValue)
              nxt_state = STEP_HOLD; // R20
          end
          else
            nxt_count = count_ff + 8'h01; // R14
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= STEP_HOLD;
      level_ff <= 4'hd;
      count_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      level_ff <= nxt_level;
      count_ff <= nxt_count;
    end
  end

  assign pumpCurrent = overrideEn ? beginValue : level_ff; // R10
endmodule // pump_current_stepper

// File: verilog/synth_calibration_test_regs.sv
// Functional notes
// R1: skip bit 0 calibrates on every rx or tx entry; 1 only rx or strobe
// R2: long-measurement bit selects 57 us calibration, else 37 us
// R3: four-bit reference current field, reset 4, feeds current calibration
// R4: six-bit current constant, also second override value when override on
// R5: without test drive, select bit picks loop filter or tuning dac value
// R6: speed field 0 normal, 1 double, 2 half, 3 undefined
// R7: current override enable substitutes six-bit override value, reset 24
// R8: read-only current result from last calibration, writes ignored
// R9: calibration pump-off bit, reset 1, disables pump during calibration
// R10: pump override uses start value, otherwise calibration sequence
// R11: force-up and force-down bits drive continuous up or down current
// R12: manual disable masks phase detector up and down pulses
// R13: phase detector delay bit picks short or long reset delay
// R14: step interval codes give 0.25, 0.5, 1 and 4 us; code 0 steps every 12 clocks of 20 ns, 0.24 us
// R15: after calibration load start current and step down to stop value
// R16: bandpass override enable applies seven-bit override capacitance
// R17: read-only seven-bit bandpass result, 0 smallest to 127 largest
// R18: software writes zero to reserved bits
// R19: tuning test drive sources node from test pin, else pin observes
// R20: stepping holds at stop value until next calibration
`include "synth_cal_defs.svh"

module synth_calibration_test_regs
  import synth_cal_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] regAddr,
  input wire logic regWrite,
  input wire logic [15:0] regWriteData,
  output logic [15:0] regReadData,
  input wire logic enterRx,
  input wire logic enterTx,
  input wire logic calibrateStrobe,
  input wire logic tuningNodeTestDrive,
  input wire logic [5:0] calOscCurrent,
  input wire logic calBandpassDone,
  input wire logic [6:0] calBandpassCap,
  output logic calBusy,
  output logic longFreqMeasurement,
  output logic [3:0] oscReferenceCurrent,
  output logic [5:0] oscCurrentConstant,
  output logic [1:0] currentCalSpeed,
  output logic oscCurrentOverrideEn,
  output logic [5:0] oscCurrentA,
  output logic [5:0] oscCurrentB,
  output logic tuningFromTestPin,
  output logic tuningFromDac,
  output logic [2:0] tuningDacValue,
  output logic pumpEnable,
  output logic pumpForceUp,
  output logic pumpForceDown,
  output logic pumpMaskPulses,
  output logic phaseDetLongDelay,
  output logic [3:0] pumpCurrent,
  output logic [6:0] bandpassCap
);
  localparam logic [15:0] RST_VAL [`REG_COUNT] = '{`RST_CAL_CONTROL,
    `RST_OSC_CURRENT, `RST_PUMP_CONTROL, `RST_BANDPASS};
  localparam logic [15:0] WMASK [`REG_COUNT] = '{`WMASK_CAL_CONTROL,
    `WMASK_OSC_CURRENT, `WMASK_PUMP_CONTROL, `WMASK_BANDPASS};

  // register file
  logic [15:0] regs_ff [`REG_COUNT];
  logic [15:0] nxt_regs [`REG_COUNT];
  logic [5:0] oscResult_ff, nxt_oscResult;
  logic [6:0] bpfResult_ff, nxt_bpfResult;
  logic [15:0] readData_ff, nxt_readData;

  function automatic logic regHit(input logic [5:0] addr, input int idx);
    regHit = (addr == 6'(`ADDR_CAL_CONTROL + idx));
  endfunction

  // writes touch only writable bits
  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi++)
    begin : g_reg
      always_comb
      begin
        nxt_regs[gi] = regs_ff[gi];
        if (regWrite && regHit(regAddr, gi))
          nxt_regs[gi] = regWriteData & WMASK[gi]; // R18
      end
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          regs_ff[gi] <= RST_VAL[gi];
        else
          regs_ff[gi] <= nxt_regs[gi];
      end
    end
  endgenerate

  wire logic [15:0] ctl = regs_ff[0];
  wire logic [15:0] osc = regs_ff[1];
  wire logic [15:0] pmp = regs_ff[2];
  wire logic [15:0] bpf = regs_ff[3];

  // calibration sequencer
  cal_state_type state_ff, nxt_state;
  logic [11:0] calCount_ff, nxt_calCount;
  logic [11:0] calLast;
  logic calRequest;
  logic calFinish;

  always_comb
  begin
    calRequest = enterRx || calibrateStrobe ||
      (enterTx && !ctl[`CTL_TX_SKIP]); // R1
    calLast = ctl[`CTL_LONG_MEAS] ? 12'(`CAL_CYCLES_LONG - 1)
      : 12'(`CAL_CYCLES_SHORT - 1); // R2
    calFinish = 1'b0;
    nxt_state = state_ff;
    nxt_calCount = calCount_ff;
    unique case (state_ff)
      CAL_IDLE:
      begin
        nxt_calCount = 12'h000;
        if (calRequest)
          nxt_state = CAL_RUN; // R1
      end
      CAL_RUN:
      begin
        if (calCount_ff >= calLast)
        begin
          calFinish = 1'b1; // R2
          nxt_state = CAL_IDLE;
          nxt_calCount = 12'h000;
        end
        else
          nxt_calCount = calCount_ff + 12'h001;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= CAL_IDLE;
      calCount_ff <= 12'h000;
    end
    else
    begin
      state_ff <= nxt_state;
      calCount_ff <= nxt_calCount;
    end
  end

  // results and read port
  always_comb
  begin
    nxt_oscResult = calFinish ? calOscCurrent : oscResult_ff; // R8
    nxt_bpfResult = calBandpassDone ? calBandpassCap : bpfResult_ff; // R17
    nxt_readData = 16'h0000;
    unique case (regAddr)
      `ADDR_CAL_CONTROL: nxt_readData = ctl;
      `ADDR_OSC_CURRENT: nxt_readData = {osc[15:6], oscResult_ff}; // R8
      `ADDR_PUMP_CONTROL: nxt_readData = pmp;
      `ADDR_BANDPASS: nxt_readData = {bpf[15:7], bpfResult_ff}; // R17
      default: nxt_readData = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      oscResult_ff <= 6'h00;
      bpfResult_ff <= 7'h00;
      readData_ff <= 16'h0000;
    end
    else
    begin
      oscResult_ff <= nxt_oscResult;
      bpfResult_ff <= nxt_bpfResult;
      readData_ff <= nxt_readData;
    end
  end

  // charge pump current sequence
  logic [3:0] stepCurrent;

  pump_current_stepper u_stepper (
    .clock(clock),
    .rst_n(rst_n),
    .startStep(calFinish),
    .overrideEn(pmp[`PMP_OVR_EN]),
    .beginValue(pmp[`PMP_BEGIN_HI:`PMP_BEGIN_LO]),
    .endValue(pmp[`PMP_END_HI:`PMP_END_LO]),
    .interval(pmp[`PMP_STEP_HI:`PMP_STEP_LO]),
    .pumpCurrent(stepCurrent)
  );

  // registered analog controls
  logic [15:0] ctlOut_ff, nxt_ctlOut;
  logic [5:0] oscA_ff, nxt_oscA;
  logic [5:0] oscB_ff, nxt_oscB;
  logic [6:0] bpfCap_ff, nxt_bpfCap;
  logic [3:0] pumpCur_ff;
  logic calBusy_ff;

  always_comb
  begin
    nxt_ctlOut = 16'h0000;
    nxt_ctlOut[0] = (nxt_state == CAL_RUN);
    nxt_ctlOut[1] = ctl[`CTL_LONG_MEAS]; // R2
    nxt_ctlOut[2] = osc[`OSC_OVR_EN];
    nxt_ctlOut[3] = tuningNodeTestDrive; // R19
    nxt_ctlOut[4] = !tuningNodeTestDrive && ctl[`CTL_DAC_EN]; // R5
    nxt_ctlOut[5] = !((nxt_state == CAL_RUN) && pmp[`PMP_CAL_OFF]); // R9
    nxt_ctlOut[6] = pmp[`PMP_UP]; // R11
    nxt_ctlOut[7] = pmp[`PMP_DOWN]; // R11
    nxt_ctlOut[8] = pmp[`PMP_DISABLE]; // R12
    nxt_ctlOut[9] = pmp[`PMP_PHASE_DET_RESET_DELAY]; // R13
    nxt_ctlOut[11:10] = osc[`OSC_SPEED_HI:`OSC_SPEED_LO]; // R6
    nxt_ctlOut[15:12] = ctl[`CTL_REF_HI:`CTL_REF_LO]; // R3
    nxt_oscA = osc[`OSC_OVR_EN] ? osc[`OSC_OVR_HI:`OSC_OVR_LO]
      : oscResult_ff; // R7
    nxt_oscB = ctl[`CTL_K_HI:`CTL_K_LO]; // R4
    nxt_bpfCap = bpf[`BPF_OVR_EN] ? bpf[`BPF_OVR_HI:`BPF_OVR_LO]
      : bpfResult_ff; // R16
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctlOut_ff <= 16'h0022;
      oscA_ff <= 6'h00;
      oscB_ff <= 6'h00;
      bpfCap_ff <= 7'h00;
      pumpCur_ff <= 4'hd;
      calBusy_ff <= 1'b0;
    end
    else
    begin
      ctlOut_ff <= nxt_ctlOut;
      oscA_ff <= nxt_oscA;
      oscB_ff <= nxt_oscB;
      bpfCap_ff <= nxt_bpfCap;
      pumpCur_ff <= stepCurrent; // R10
      calBusy_ff <= nxt_ctlOut[0];
    end
  end

  assign regReadData = readData_ff;
  assign calBusy = calBusy_ff;
  assign longFreqMeasurement = ctlOut_ff[1];
  assign oscCurrentOverrideEn = ctlOut_ff[2];
  assign tuningFromTestPin = ctlOut_ff[3];
  assign tuningFromDac = ctlOut_ff[4];
  assign pumpEnable = ctlOut_ff[5];
  assign pumpForceUp = ctlOut_ff[6];
  assign pumpForceDown = ctlOut_ff[7];
  assign pumpMaskPulses = ctlOut_ff[8];
  assign phaseDetLongDelay = ctlOut_ff[9];
  assign currentCalSpeed = ctlOut_ff[11:10];
  assign oscReferenceCurrent = ctlOut_ff[15:12];
  assign oscCurrentA = oscA_ff;
  assign oscCurrentB = oscB_ff;
  assign oscCurrentConstant = oscB_ff; // R4
  assign tuningDacValue = ctl[`CTL_DAC_HI:`CTL_DAC_LO]; // R5
  assign pumpCurrent = pumpCur_ff;
  assign bandpassCap = bpfCap_ff;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_tx_cal;
    (state_ff == CAL_IDLE) && enterTx && !ctl[`CTL_TX_SKIP] |=> calBusy;
  endproperty
  a_tx_cal: assert property (p_tx_cal) else $error("tx entry no cal"); // R1

  property p_tx_skip;
    (state_ff == CAL_IDLE) && enterTx && ctl[`CTL_TX_SKIP] && !enterRx
      && !calibrateStrobe |=> !calBusy;
  endproperty
  a_tx_skip: assert property (p_tx_skip) else $error("tx not skipped"); // R1

  property p_cal_len;
    $fell(calBusy) |-> $past(calCount_ff) == $past(calLast);
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal length wrong"); // R2

  property p_osc_a;
    ##1 oscCurrentA == ($past(osc[`OSC_OVR_EN])
      ? $past(osc[`OSC_OVR_HI:`OSC_OVR_LO]) : $past(oscResult_ff));
  endproperty
  a_osc_a: assert property (p_osc_a) else $error("osc current wrong"); // R7

  property p_res_ro;
    regWrite && (regAddr == `ADDR_OSC_CURRENT) && !calFinish
      |=> $stable(oscResult_ff);
  endproperty
  a_res_ro: assert property (p_res_ro) else $error("result written"); // R8

  property p_pump_cal;
    calBusy && pmp[`PMP_CAL_OFF] && $past(pmp[`PMP_CAL_OFF]) |-> !pumpEnable;
  endproperty
  a_pump_cal: assert property (p_pump_cal) else $error("pump on in cal"); // R9

  property p_force;
    ##1 pumpForceUp == $past(pmp[`PMP_UP])
      && pumpForceDown == $past(pmp[`PMP_DOWN]);
  endproperty
  a_force: assert property (p_force) else $error("force bits wrong"); // R11

  property p_bpf;
    bpf[`BPF_OVR_EN] ##1 bpf[`BPF_OVR_EN]
      |-> bandpassCap == $past(bpf[`BPF_OVR_HI:`BPF_OVR_LO]);
  endproperty
  a_bpf: assert property (p_bpf) else $error("bpf override wrong"); // R16

  property p_tune;
    ##1 tuningFromDac == (!$past(tuningNodeTestDrive)
      && $past(ctl[`CTL_DAC_EN]));
  endproperty
  a_tune: assert property (p_tune) else $error("tuning source wrong"); // R5

  property p_pump_override;
    pmp[`PMP_OVR_EN] ##1 pmp[`PMP_OVR_EN]
      |-> pumpCurrent == $past(pmp[`PMP_BEGIN_HI:`PMP_BEGIN_LO]);
  endproperty
  a_pump_override: assert property (p_pump_override) // R10
    else $error("pump override wrong");

  c_cal_run: cover property (calFinish ##1 $fell(calBusy));
  c_tx_skip: cover property (enterTx && ctl[`CTL_TX_SKIP]);
  c_step: cover property (calFinish ##[1:300]
    $changed(pumpCurrent));
  c_bpf_done: cover property (calBandpassDone);
endmodule // synth_calibration_test_regs

// File: verification/synth_calibration_test_regs_bench.sv
`include "synth_cal_defs.svh"

`define EXPECT_EQ(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      $display("BAD %s expected %0h seen %0h", what, exp, got); \
      fails++; \
    end \
  end

module synth_calibration_test_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int STEP_TABLE[4] = '{`STEP_CYCLES_0, `STEP_CYCLES_1,
    `STEP_CYCLES_2, `STEP_CYCLES_3};

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic regWrite = 1'b0;
  logic [15:0] regWriteData = 16'h0000;
  logic enterRx = 1'b0;
  logic enterTx = 1'b0;
  logic calibrateStrobe = 1'b0;
  logic tuningNodeTestDrive = 1'b0;
  logic [5:0] calOscCurrent = 6'h00;
  logic calBandpassDone = 1'b0;
  logic [6:0] calBandpassCap = 7'h00;
  logic [15:0] regReadData;
  logic calBusy, longFreqMeasurement, oscCurrentOverrideEn;
  logic [3:0] oscReferenceCurrent, pumpCurrent;
  logic [5:0] oscCurrentConstant, oscCurrentA, oscCurrentB;
  logic [1:0] currentCalSpeed;
  logic tuningFromTestPin, tuningFromDac, pumpEnable, pumpForceUp;
  logic pumpForceDown, pumpMaskPulses, phaseDetLongDelay;
  logic [2:0] tuningDacValue;
  logic [6:0] bandpassCap;
  int fails = 0;
  int check_count = 0;

  always #10 clock = ~clock;

  synth_calibration_test_regs i_dut (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regReadData(regReadData),
    .enterRx(enterRx), .enterTx(enterTx), .calibrateStrobe(calibrateStrobe),
    .tuningNodeTestDrive(tuningNodeTestDrive),
    .calOscCurrent(calOscCurrent), .calBandpassDone(calBandpassDone),
    .calBandpassCap(calBandpassCap), .calBusy(calBusy),
    .longFreqMeasurement(longFreqMeasurement),
    .oscReferenceCurrent(oscReferenceCurrent),
    .oscCurrentConstant(oscCurrentConstant),
    .currentCalSpeed(currentCalSpeed),
    .oscCurrentOverrideEn(oscCurrentOverrideEn),
    .oscCurrentA(oscCurrentA), .oscCurrentB(oscCurrentB),
    .tuningFromTestPin(tuningFromTestPin), .tuningFromDac(tuningFromDac),
    .tuningDacValue(tuningDacValue), .pumpEnable(pumpEnable),
    .pumpForceUp(pumpForceUp), .pumpForceDown(pumpForceDown),
    .pumpMaskPulses(pumpMaskPulses), .phaseDetLongDelay(phaseDetLongDelay),
    .pumpCurrent(pumpCurrent), .bandpassCap(bandpassCap)
  );

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic reg_write(input logic [5:0] addr, input logic [15:0] data);
    @(negedge clock);
    regAddr = addr;
    regWriteData = data;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask

  task automatic check_reg(input logic [5:0] addr, input logic [15:0] exp);
    @(negedge clock);
    regAddr = addr;
    @(negedge clock);
    `EXPECT_EQ("regReadData", exp, regReadData)
  endtask

  task automatic pulse(input int which);
    @(negedge clock);
    enterRx = (which == 0);
    enterTx = (which == 1);
    calibrateStrobe = (which == 2);
    @(negedge clock);
    {enterRx, enterTx, calibrateStrobe} = 3'b000;
  endtask

  // wait for calBusy to reach a level, bounded
  task automatic wait_busy(input logic level, input int limit);
    int n;
    n = 0;
    while (calBusy !== level && n < limit)
    begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic test_reset();
    check_reg(`ADDR_CAL_CONTROL, `RST_CAL_CONTROL);
    check_reg(`ADDR_OSC_CURRENT, `RST_OSC_CURRENT);
    check_reg(`ADDR_PUMP_CONTROL, `RST_PUMP_CONTROL);
    check_reg(`ADDR_BANDPASS, `RST_BANDPASS);
    `EXPECT_EQ("oscReferenceCurrent", 4'h4, oscReferenceCurrent)
    `EXPECT_EQ("tuningDacValue", 3'h2, tuningDacValue)
    `EXPECT_EQ("pumpCurrent", 4'hd, pumpCurrent)
    `EXPECT_EQ("pumpEnable", 1'b1, pumpEnable)
    `EXPECT_EQ("longFreqMeasurement", 1'b1, longFreqMeasurement)
    `EXPECT_EQ("oscCurrentOverrideEn", 1'b0, oscCurrentOverrideEn)
  endtask

  task automatic test_fields();
    reg_write(`ADDR_CAL_CONTROL, 16'hffff);
    reg_write(`ADDR_OSC_CURRENT, 16'h7fff);
    reg_write(`ADDR_PUMP_CONTROL, 16'hffff);
    reg_write(`ADDR_BANDPASS, 16'h7fff);
    check_reg(`ADDR_CAL_CONTROL, 16'hffff);
    check_reg(`ADDR_OSC_CURRENT, 16'h7fc0);
    check_reg(`ADDR_PUMP_CONTROL, 16'hffff);
    check_reg(`ADDR_BANDPASS, 16'h7f80);
    check_reg(6'h2c, 16'h0000);
    `EXPECT_EQ("oscCurrentA", 6'h3f, oscCurrentA)
    `EXPECT_EQ("oscCurrentB", 6'h3f, oscCurrentB)
    `EXPECT_EQ("oscCurrentConstant", 6'h3f, oscCurrentConstant)
    `EXPECT_EQ("longFreqMeasurement", 1'b1, longFreqMeasurement)
    `EXPECT_EQ("oscCurrentOverrideEn", 1'b1, oscCurrentOverrideEn)
    `EXPECT_EQ("currentCalSpeed", 2'h3, currentCalSpeed)
    `EXPECT_EQ("tuningFromDac", 1'b1, tuningFromDac)
    `EXPECT_EQ("pumpForceUp", 1'b1, pumpForceUp)
    `EXPECT_EQ("pumpForceDown", 1'b1, pumpForceDown)
    `EXPECT_EQ("pumpMaskPulses", 1'b1, pumpMaskPulses)
    `EXPECT_EQ("phaseDetLongDelay", 1'b1, phaseDetLongDelay)
    `EXPECT_EQ("pumpCurrent", 4'hf, pumpCurrent)
    `EXPECT_EQ("bandpassCap", 7'h7f, bandpassCap)
    @(negedge clock);
    tuningNodeTestDrive = 1'b1;
    repeat (2) @(negedge clock);
    `EXPECT_EQ("tuningFromTestPin", 1'b1, tuningFromTestPin)
    `EXPECT_EQ("tuningFromDac", 1'b0, tuningFromDac)
    tuningNodeTestDrive = 1'b0;
    reg_write(`ADDR_PUMP_CONTROL, 16'h0000);
    repeat (2) @(negedge clock);
    `EXPECT_EQ("phaseDetLongDelay", 1'b0, phaseDetLongDelay)
    `EXPECT_EQ("pumpMaskPulses", 1'b0, pumpMaskPulses)
  endtask

  task automatic test_bandpass();
    reg_write(`ADDR_BANDPASS, 16'h0000);
    calBandpassCap = 7'h7f;
    calBandpassDone = 1'b1;
    @(negedge clock);
    calBandpassDone = 1'b0;
    check_reg(`ADDR_BANDPASS, 16'h007f);
    `EXPECT_EQ("bandpassCap", 7'h7f, bandpassCap)
    reg_write(`ADDR_BANDPASS, 16'h4a80);
    check_reg(`ADDR_BANDPASS, 16'h4aff);
    `EXPECT_EQ("bandpassCap", 7'h15, bandpassCap)
  endtask

  // one calibration per step code, triggered by rx, tx, strobe then rx, with stepping after
  task automatic test_calibration();
    int n;
    int expCycles;
    for (int i = 0; i < 4; i++)
    begin
      reg_write(`ADDR_CAL_CONTROL, {1'b0, i[1], 14'h1002});
      reg_write(`ADDR_OSC_CURRENT, 16'h0000);
      reg_write(`ADDR_PUMP_CONTROL, {6'h20, i[1:0], 8'h69});
      calOscCurrent = 6'h20 + 6'(i);
      pulse(i == 3 ? 0 : i);
      wait_busy(1'b1, 4);
      `EXPECT_EQ("calBusy", 1'b1, calBusy)
      `EXPECT_EQ("pumpEnable", 1'b0, pumpEnable)
      n = 0;
      while (calBusy === 1'b1 && n < 4000)
      begin
        n++;
        @(negedge clock);
      end
      expCycles = i[1] ? `CAL_CYCLES_LONG : `CAL_CYCLES_SHORT;
      `EXPECT_EQ("calCycles", expCycles, n)
      repeat (3) @(negedge clock);
      `EXPECT_EQ("pumpEnable", 1'b1, pumpEnable)
      `EXPECT_EQ("pumpCurrent", 4'h9, pumpCurrent)
      `EXPECT_EQ("oscCurrentA", 6'h20 + 6'(i), oscCurrentA)
      n = 0;
      while (pumpCurrent !== 4'h8 && n < 300)
      begin
        n++;
        @(negedge clock);
      end
      n = 0;
      while (pumpCurrent === 4'h8 && n < 300)
      begin
        n++;
        @(negedge clock);
      end
      `EXPECT_EQ("stepCycles", STEP_TABLE[i], n)
      repeat (1000) @(negedge clock);
      `EXPECT_EQ("pumpCurrent", 4'h6, pumpCurrent)
    end
    check_reg(`ADDR_OSC_CURRENT, 16'h0023);
    reg_write(`ADDR_PUMP_CONTROL, 16'hc063);
    repeat (2) @(negedge clock);
    `EXPECT_EQ("pumpCurrent", 4'h3, pumpCurrent)
  endtask

  task automatic test_skip();
    reg_write(`ADDR_CAL_CONTROL, 16'h9002);
    pulse(1);
    repeat (5) @(negedge clock);
    `EXPECT_EQ("calBusy", 1'b0, calBusy)
    pulse(2);
    wait_busy(1'b1, 4);
    `EXPECT_EQ("calBusy", 1'b1, calBusy)
    wait_busy(1'b0, 3000);
    pulse(0);
    wait_busy(1'b1, 4);
    `EXPECT_EQ("calBusy", 1'b1, calBusy)
  endtask

  initial
  begin
    repeat (60000) @(posedge clock);
    fails++;
    close_out();
  end

  initial
  begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    test_reset();
    test_fields();
    test_bandpass();
    test_calibration();
    test_skip();
    close_out();
  end
endmodule // synth_calibration_test_regs_bench
